// file: src/bvc_pkg.sv
// constants, tables and types of the boost voltage control block
// assumes one 20 MHz clock and configuration fields held steady by their store
package bvc_pkg;

  // ------------------------------------------------------------
  // clock and switching frequencies
  // ------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int FSW_LO_KHZ = 312;
  localparam int FSW_MID_KHZ = 625;
  localparam int FSW_HI_KHZ = 1250;
  localparam int PER_W = 7;
  localparam logic [PER_W-1:0] PER_LO = PER_W'(CLK_HZ / (1000 * FSW_LO_KHZ));
  localparam logic [PER_W-1:0] PER_MID = PER_W'(CLK_HZ / (1000 * FSW_MID_KHZ));
  localparam logic [PER_W-1:0] PER_HI = PER_W'(CLK_HZ / (1000 * FSW_HI_KHZ));
  localparam logic [1:0] FREQ_LO = 2'h0;
  localparam logic [1:0] FREQ_MID = 2'h1;
  localparam logic [1:0] FREQ_HI = 2'h2;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SS_TIME_US = 8000;
  localparam int UPD_TIME_US = 1000;
  localparam int SS_CYCLES_DEF = SS_TIME_US * (CLK_HZ / 1_000_000);
  localparam int UPD_CYCLES_DEF = UPD_TIME_US * (CLK_HZ / 1_000_000);
  localparam logic [1:0] SPREAD_TOP = 2'h3;

  // ------------------------------------------------------------
  // voltages in millivolts
  // ------------------------------------------------------------
  localparam int MV_W = 16;
  localparam logic [MV_W-1:0] FLOOR_LO_MV = MV_W'(7000);
  localparam logic [MV_W-1:0] FLOOR_HI_MV = MV_W'(16000);
  localparam logic [MV_W-1:0] SP_LSB_MV = MV_W'(420);
  localparam logic [MV_W-1:0] CEIL_R0_MV [8] = '{
    MV_W'(21000), MV_W'(21000), MV_W'(21000), MV_W'(21000),
    MV_W'(21000), MV_W'(25000), MV_W'(30000), MV_W'(34000)};
  localparam logic [MV_W-1:0] CEIL_R1_MV [8] = '{
    MV_W'(21000), MV_W'(21000), MV_W'(21000), MV_W'(25000),
    MV_W'(30000), MV_W'(34500), MV_W'(39000), MV_W'(43000)};
  localparam int STR_N = 6;

  // converter sequencing
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_SOFT = 3'b010,
    ST_RUN = 3'b100
  } bvc_state_e;

  // switching period for a two-bit frequency code; the unused code runs slowest
  function automatic logic [PER_W-1:0] bvcPeriodOf(input logic [1:0] code);
    unique case (code)
      FREQ_MID: bvcPeriodOf = PER_MID;
      FREQ_HI: bvcPeriodOf = PER_HI;
      default: bvcPeriodOf = PER_LO;
    endcase
  endfunction : bvcPeriodOf

  // strings taking part for a phase-shift pattern: pattern n uses strings 0..n, patterns 6 and 7 use strings 0..5
  function automatic logic [STR_N-1:0] bvcStringMask(input logic [2:0] pat);
    logic [3:0] cnt;
    cnt = (pat > 3'h5) ? 4'h6 : ({1'h0, pat} + 4'h1);
    bvcStringMask = STR_N'((7'h01 << cnt) - 7'h01);
  endfunction : bvcStringMask

endpackage : bvc_pkg

// file: src/bvc_sw_timer.sv
// switching period counter and power switch gate
// assumes period and on-time cap held steady within a period, trip synchronised
`timescale 1ns/10ps
module bvc_sw_timer #(
  parameter int PW = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic [PW-1:0] period,
  input wire logic [PW-1:0] onMax,
  input wire logic trip,
  // switch
  output logic swOn_q,
  output logic cycStart_q
);
  logic [PW-1:0] cnt_q;

  // ------------------------------------------------------------
  // period counter
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (!run || cnt_q == period - PW'(1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + PW'(1);
    end
  end

  // one pulse at the start of each period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cycStart_q <= 1'h0;
    end else begin
      cycStart_q <= run && cnt_q == '0;
    end
  end

  // gate opens at period start, closes on current trip or on-time cap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      swOn_q <= 1'h0;
    end else if (!run) begin
      swOn_q <= 1'h0;
    end else if (cnt_q == '0) begin
      swOn_q <= 1'h1; // trip blanked in the first cycle
    end else if (trip || cnt_q >= onMax) begin
      swOn_q <= 1'h0;
    end
  end

endmodule : bvc_sw_timer

// file: src/bvc_track_loop.sv
// headroom tracking loop: moves the boost target one step per update tick
// assumes start value already clamped to the ceiling by the caller
`timescale 1ns/10ps
module bvc_track_loop #(
  parameter int MW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic tick,
  input wire logic anyLow,
  input wire logic anyHigh,
  // limits and steps
  input wire logic [MW-1:0] startMv,
  input wire logic [MW-1:0] ceilMv,
  input wire logic [MW-1:0] upMv,
  input wire logic [MW-1:0] dnMv,
  // result
  output logic [MW-1:0] loopMv_q,
  output logic atCeil_q
);
  logic [MW:0] upSum;
  logic [MW:0] dnDiff;

  // candidate values, one bit wider to catch overflow and underflow
  always_comb begin
    upSum = {1'h0, loopMv_q} + {1'h0, upMv};
    dnDiff = {1'h0, loopMv_q} - {1'h0, dnMv};
  end

  // ------------------------------------------------------------
  // target update: raise wins over lower
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loopMv_q <= '0;
    end else if (!enable) begin
      loopMv_q <= startMv; // [R7]
    end else if (tick && anyLow) begin
      loopMv_q <= (upSum > {1'h0, ceilMv}) ? ceilMv : upSum[MW-1:0]; // [R4] [R6] [R8]
    end else if (tick && anyHigh) begin
      loopMv_q <= (dnDiff[MW] || dnDiff[MW-1:0] < startMv) ? startMv
                  : dnDiff[MW-1:0]; // [R5] [R6] [R7]
    end
  end

  // ceiling flag, shows an open string held at the limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      atCeil_q <= 1'h0;
    end else begin
      atCeil_q <= enable && loopMv_q == ceilMv; // [R8]
    end
  end

endmodule : bvc_track_loop

// file: src/bvc_boost_ctrl.sv
// top of the boost voltage control: frequency, target voltage, drivers
// assumes configuration fields come from a store on the same clock;
// comparator, trip and resistor-decode inputs are asynchronous pins
//
// How it works
// (R1) all converter timing counts cycles of the 20 MHz internal clock
// (R2) resistor select high takes frequency from resistor decode, else stored code
// (R3) frequency code 00/01/10 gives 312/625/1250 kHz; 11 must not be used
// (R4) tracking raises target when any monitored string sits below headroom threshold
// (R5) tracking lowers target when a string exceeds threshold plus hysteresis
// (R6) raise steps use the step-up field, lower steps the step-down field
// (R7) tracking starts at the setpoint value and never goes below it
// (R8) tracking target is clamped at the ceiling from the ceiling code
// (R9) only strings enabled by the phase-shift pattern are monitored
// (R10) tracking enable high selects tracking mode, low selects manual
// (R11) manual target is floor plus 0.42 V times setpoint code
// (R12) manual target is held inside the floor-to-ceiling window
// (R13) up to three parallel switch drivers set the transition speed
// (R14) second and third driver enables add drivers beside the first
// (R15) spread spectrum varies the switching period from cycle to cycle
// (R16) soft start caps switch on-time, limiting peak inductor current
// (R17) floor range 0 gives 7 V, range 1 gives 16 V
// (R18) tracking takes at most one step per fixed update interval
`timescale 1ns/10ps
module bvc_boost_ctrl #(
  parameter int SS_CYCLES = bvc_pkg::SS_CYCLES_DEF,
  parameter int UPD_CYCLES = bvc_pkg::UPD_CYCLES_DEF,
  parameter int SP_W = 7,
  parameter int ST_W = 2,
  parameter int TH_W = 3,
  parameter int HY_W = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // converter control and frequency configuration
  input wire logic boostEn,
  input wire logic resistorFreqSelect,
  input wire logic [1:0] switchFreqCode,
  input wire logic spreadEnable,
  // voltage configuration
  input wire logic trackEnable,
  input wire logic [SP_W-1:0] boostSetpoint,
  input wire logic [2:0] boostCeilingCode,
  input wire logic boostFloorRange,
  input wire logic [ST_W-1:0] stepUpCode,
  input wire logic [ST_W-1:0] stepDownCode,
  input wire logic [TH_W-1:0] stringHeadroomThreshold,
  input wire logic [HY_W-1:0] headroomHysteresis,
  input wire logic [2:0] phaseShiftPattern,
  // driver configuration
  input wire logic secondDriverEnable,
  input wire logic thirdDriverEnable,
  // asynchronous sense pins
  input wire logic [bvc_pkg::STR_N-1:0] stringLowPin,
  input wire logic [bvc_pkg::STR_N-1:0] stringHighPin,
  input wire logic currentTripPin,
  input wire logic [1:0] freqSetResistorCode,
  // switch outputs
  output logic swGate,
  output logic [2:0] drvEn,
  output logic softStart,
  // voltage outputs
  output logic [bvc_pkg::MV_W-1:0] targetMv,
  output logic [TH_W-1:0] headroomThrOut,
  output logic [HY_W-1:0] hysteresisOut,
  output logic trackActive,
  output logic atCeiling
);
  import bvc_pkg::*;

  localparam int SS_W = $clog2(SS_CYCLES + 1);
  localparam int UP_W = $clog2(UPD_CYCLES + 1);
  localparam int SYN_W = 2 * STR_N + 3;

  bvc_state_e state_q;
  logic [SYN_W-1:0] syn1_q;
  logic [SYN_W-1:0] syn2_q;
  logic [STR_N-1:0] lowSync;
  logic [STR_N-1:0] highSync;
  logic tripSync;
  logic [1:0] resCodeSync;
  logic [SS_W-1:0] ssCnt_q;
  logic [UP_W-1:0] updCnt_q;
  logic tick_q;
  logic [1:0] freqSel;
  logic [PER_W-1:0] basePer;
  logic [PER_W-1:0] period_q;
  logic [PER_W-1:0] onMax_q;
  logic [1:0] ssOff_q;
  logic ssDown_q;
  logic cycStart;
  logic swOn;
  logic [MV_W-1:0] floorMv;
  logic [MV_W-1:0] ceilMv;
  logic [MV_W:0] manRaw;
  logic [MV_W-1:0] manualMv;
  logic [MV_W-1:0] upMv;
  logic [MV_W-1:0] dnMv;
  logic [STR_N-1:0] mask;
  logic anyLow;
  logic anyHigh;
  logic loopEn;
  logic [MV_W-1:0] loopMv;
  logic loopCeil;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syn1_q <= '0;
      syn2_q <= '0;
    end else begin
      syn1_q <= {stringLowPin, stringHighPin, currentTripPin, freqSetResistorCode};
      syn2_q <= syn1_q;
    end
  end

  // split the second stage
  always_comb begin
    lowSync = syn2_q[SYN_W-1 -: STR_N];
    highSync = syn2_q[STR_N+2 -: STR_N];
    tripSync = syn2_q[2];
    resCodeSync = syn2_q[1:0];
  end

  // ------------------------------------------------------------
  // sequencing: off, soft start, run
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
    end else if (!boostEn) begin
      state_q <= ST_OFF;
    end else begin
      unique case (state_q)
        ST_OFF: state_q <= ST_SOFT;
        ST_SOFT: begin
          if (ssCnt_q == SS_W'(SS_CYCLES - 1)) begin
            state_q <= ST_RUN; // [R16]
          end
        end
        ST_RUN: state_q <= ST_RUN;
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // soft start duration counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ssCnt_q <= '0;
    end else if (state_q != ST_SOFT) begin
      ssCnt_q <= '0;
    end else begin
      ssCnt_q <= ssCnt_q + SS_W'(1); // [R1]
    end
  end

  // ------------------------------------------------------------
  // update interval for the tracking loop
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      updCnt_q <= '0;
      tick_q <= 1'h0;
    end else if (updCnt_q == UP_W'(UPD_CYCLES - 1)) begin
      updCnt_q <= '0;
      tick_q <= 1'h1; // [R18]
    end else begin
      updCnt_q <= updCnt_q + UP_W'(1);
      tick_q <= 1'h0;
    end
  end

  // ------------------------------------------------------------
  // switching frequency and spread spectrum
  // ------------------------------------------------------------
  always_comb begin
    freqSel = resistorFreqSelect ? resCodeSync : switchFreqCode; // [R2]
    basePer = bvcPeriodOf(freqSel); // [R3]
  end

  // triangle offset stepped once per period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ssOff_q <= '0;
      ssDown_q <= 1'h0;
    end else if (!spreadEnable) begin
      ssOff_q <= '0;
      ssDown_q <= 1'h0;
    end else if (cycStart) begin
      if (ssDown_q) begin
        ssOff_q <= ssOff_q - 2'h1; // [R15]
        ssDown_q <= ssOff_q != 2'h1;
      end else begin
        ssOff_q <= ssOff_q + 2'h1; // [R15]
        ssDown_q <= ssOff_q == SPREAD_TOP - 2'h1;
      end
    end
  end

  // period and on-time cap, reloaded every cycle while off and otherwise at a period boundary
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_q <= PER_LO;
      onMax_q <= PER_LO >> 1;
    end else if (state_q == ST_OFF || cycStart) begin
      period_q <= basePer + PER_W'(ssOff_q); // [R15]
      if (state_q == ST_RUN) begin
        onMax_q <= basePer - (basePer >> 3);
      end else begin
        onMax_q <= basePer >> 1; // [R16]
      end
    end
  end

  bvc_sw_timer #(
    .PW(PER_W)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(state_q != ST_OFF),
    .period(period_q),
    .onMax(onMax_q),
    .trip(tripSync),
    .swOn_q(swOn),
    .cycStart_q(cycStart)
  );

  // ------------------------------------------------------------
  // voltage window and manual target
  // ------------------------------------------------------------
  always_comb begin
    floorMv = boostFloorRange ? FLOOR_HI_MV : FLOOR_LO_MV; // [R17]
    ceilMv = boostFloorRange ? CEIL_R1_MV[boostCeilingCode]
             : CEIL_R0_MV[boostCeilingCode];
    manRaw = (MV_W+1)'(floorMv) + (MV_W+1)'(SP_LSB_MV * (MV_W+1)'(boostSetpoint)); // [R11]
    manualMv = (manRaw > (MV_W+1)'(ceilMv)) ? ceilMv : manRaw[MV_W-1:0]; // [R12]
    upMv = MV_W'(SP_LSB_MV * (MV_W'(stepUpCode) + MV_W'(1))); // [R6]
    dnMv = MV_W'(SP_LSB_MV * (MV_W'(stepDownCode) + MV_W'(1))); // [R6]
  end

  // ------------------------------------------------------------
  // string monitoring
  // ------------------------------------------------------------
  always_comb begin
    mask = bvcStringMask(phaseShiftPattern);
    anyLow = |(lowSync & mask); // [R9] [R4]
    anyHigh = |(highSync & mask); // [R9] [R5]
    loopEn = trackEnable && state_q == ST_RUN; // [R10]
  end

  bvc_track_loop #(
    .MW(MV_W)
  ) u_loop (
    .clk(clk),
    .rst_n(rst_n),
    .enable(loopEn),
    .tick(tick_q),
    .anyLow(anyLow),
    .anyHigh(anyHigh),
    .startMv(manualMv),
    .ceilMv(ceilMv),
    .upMv(upMv),
    .dnMv(dnMv),
    .loopMv_q(loopMv),
    .atCeil_q(loopCeil)
  );

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      targetMv <= '0;
      trackActive <= 1'h0;
    end else begin
      targetMv <= trackEnable ? loopMv : manualMv; // [R10]
      trackActive <= loopEn;
    end
  end

  // switch gate and driver strength
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      swGate <= 1'h0;
      drvEn <= '0;
      softStart <= 1'h0;
    end else begin
      swGate <= swOn;
      softStart <= state_q == ST_SOFT; // [R16]
      if (state_q == ST_OFF) begin
        drvEn <= '0;
      end else begin
        drvEn <= {thirdDriverEnable, secondDriverEnable, 1'h1}; // [R13] [R14]
      end
    end
  end

  // comparator settings and ceiling flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      headroomThrOut <= '0;
      hysteresisOut <= '0;
      atCeiling <= 1'h0;
    end else begin
      headroomThrOut <= stringHeadroomThreshold; // [R4]
      hysteresisOut <= headroomHysteresis; // [R5]
      atCeiling <= loopCeil;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_rise_req;
    loopEn && tick_q && anyLow && (loopMv + upMv <= ceilMv);
  endsequence

  sequence s_fall_req;
    loopEn && tick_q && !anyLow && anyHigh && (loopMv >= manualMv + dnMv);
  endsequence

  property p_raise;
    @(posedge clk) disable iff (!rst_n)
      s_rise_req |=> loopMv == $past(loopMv) + $past(upMv);
  endproperty
  a_raise: assert property (p_raise) else $error("raise step wrong"); // [R4] [R6]

  property p_lower;
    @(posedge clk) disable iff (!rst_n)
      s_fall_req |=> loopMv == $past(loopMv) - $past(dnMv);
  endproperty
  a_lower: assert property (p_lower) else $error("lower step wrong"); // [R5] [R6]

  property p_floor;
    @(posedge clk) disable iff (!rst_n)
      loopEn && $stable(manualMv) |=> loopMv >= manualMv;
  endproperty
  a_floor: assert property (p_floor) else $error("target below setpoint"); // [R7]

  property p_ceil;
    @(posedge clk) disable iff (!rst_n)
      loopEn && $stable(ceilMv) |=> loopMv <= ceilMv;
  endproperty
  a_ceil: assert property (p_ceil) else $error("target above ceiling"); // [R8]

  property p_mask;
    @(posedge clk) disable iff (!rst_n)
      loopEn && tick_q && (lowSync & mask) == '0 && (highSync & mask) == '0
      |=> $stable(loopMv);
  endproperty
  a_mask: assert property (p_mask) else $error("disabled string moved target"); // [R9]

  property p_manual;
    @(posedge clk) disable iff (!rst_n)
      (rst_n && !trackEnable) [*2] ##0 $stable(manualMv) |-> targetMv == manualMv;
  endproperty
  a_manual: assert property (p_manual) else $error("manual target wrong"); // [R11] [R12]

  property p_drivers;
    @(posedge clk) disable iff (!rst_n)
      state_q != ST_OFF |=> drvEn == {$past(thirdDriverEnable), $past(secondDriverEnable), 1'h1};
  endproperty
  a_drivers: assert property (p_drivers) else $error("driver enables wrong"); // [R13] [R14]

  property p_soft;
    @(posedge clk) disable iff (!rst_n)
      state_q == ST_SOFT && cycStart |=> onMax_q == $past(basePer) >> 1;
  endproperty
  a_soft: assert property (p_soft) else $error("soft start cap missing"); // [R16]

  property p_spread;
    @(posedge clk) disable iff (!rst_n)
      spreadEnable [*2] ##0 cycStart |=> ssOff_q != $past(ssOff_q);
  endproperty
  a_spread: assert property (p_spread) else $error("spread offset stuck"); // [R15]

  property p_tick;
    @(posedge clk) disable iff (!rst_n)
      tick_q |=> !tick_q [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("update ticks too close"); // [R18]

  property p_src;
    @(posedge clk) disable iff (!rst_n)
      (state_q == ST_OFF) && !spreadEnable |=> period_q == $past(basePer);
  endproperty
  a_src: assert property (p_src) else $error("period source wrong"); // [R2] [R3] [R1]

endmodule : bvc_boost_ctrl

// file: dv/bvc_power_stage.sv
// behavioural boost power stage with six string sense points
// assumes targetMv stands for the output voltage the stage settles at
`timescale 1ns/10ps
module bvc_power_stage (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // from the control block
  input wire logic swGate,
  input wire logic [bvc_pkg::MV_W-1:0] targetMv,
  // scenario settings
  input wire logic [bvc_pkg::MV_W-1:0] reqMv,
  input wire logic [bvc_pkg::MV_W-1:0] marginMv,
  input wire logic [bvc_pkg::STR_N-1:0] openMask,
  input wire logic [7:0] tripDelay,
  // sense outputs
  output logic [bvc_pkg::STR_N-1:0] stringLowPin,
  output logic [bvc_pkg::STR_N-1:0] stringHighPin,
  output logic currentTripPin
);
  import bvc_pkg::*;
  logic [7:0] onCnt_q;
  // an open string never gets headroom; the others compare output with need
  always_comb begin
    for (int i = 0; i < STR_N; i++) begin
      stringLowPin[i] = openMask[i] | (targetMv < reqMv);
      stringHighPin[i] = !openMask[i] & (32'(targetMv) > 32'(reqMv) + 32'(marginMv));
    end
  end
  // inductor current ramps while the switch is on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) onCnt_q <= 8'h0;
    else if (swGate) onCnt_q <= onCnt_q + 8'h1;
    else onCnt_q <= 8'h0;
  end
  // peak current reached after tripDelay cycles of on-time
  assign currentTripPin = swGate & (onCnt_q >= tripDelay);
endmodule : bvc_power_stage

// file: dv/bvc_boost_ctrl_tb_top.sv
// self-checking bench for the boost voltage control top
// assumes the power stage model of bvc_power_stage.sv on the far side
`timescale 1ns/10ps
`define CHK(w, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp=%0d got=%0d", w, e, g); end end
module bvc_boost_ctrl_tb_top;
  import bvc_pkg::*;
  localparam int SS = 50;
  localparam int UPD = 20;
  logic clk = 1'b0, rst_n = 1'b0, boostEn = 1'b0, resistorFreqSelect = 1'b0;
  logic spreadEnable = 1'b0, trackEnable = 1'b0, boostFloorRange = 1'b0;
  logic secondDriverEnable = 1'b0, thirdDriverEnable = 1'b0, currentTripPin;
  logic [1:0] switchFreqCode = 2'h0, stepUpCode = 2'h1, stepDownCode = 2'h2;
  logic [1:0] headroomHysteresis = 2'h2, freqSetResistorCode = 2'h0;
  logic [6:0] boostSetpoint = 7'h0a;
  logic [2:0] boostCeilingCode = 3'h7, stringHeadroomThreshold = 3'h5;
  logic [2:0] phaseShiftPattern = 3'h5, drvEn, headroomThrOut;
  logic [5:0] stringLowPin, stringHighPin, openMask = 6'h00;
  logic [15:0] targetMv, reqMv = 16'h0000, marginMv = 16'h0000;
  logic [7:0] tripDelay = 8'hc8;
  logic [1:0] hysteresisOut;
  logic swGate, softStart, trackActive, atCeiling;
  int n_errors = 0, checked = 0;

  // design and far-side model
  bvc_boost_ctrl #(.SS_CYCLES(SS), .UPD_CYCLES(UPD)) DUT (.clk, .rst_n, .boostEn,
    .resistorFreqSelect, .switchFreqCode, .spreadEnable, .trackEnable, .boostSetpoint,
    .boostCeilingCode, .boostFloorRange, .stepUpCode, .stepDownCode,
    .stringHeadroomThreshold, .headroomHysteresis, .phaseShiftPattern,
    .secondDriverEnable, .thirdDriverEnable, .stringLowPin, .stringHighPin,
    .currentTripPin, .freqSetResistorCode, .swGate, .drvEn, .softStart, .targetMv,
    .headroomThrOut, .hysteresisOut, .trackActive, .atCeiling);
  bvc_power_stage stage (.clk, .rst_n, .swGate, .targetMv, .reqMv, .marginMv,
    .openMask, .tripDelay, .stringLowPin, .stringHighPin, .currentTripPin);

  // clock
  always #5 clk = ~clk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // cycles until the next rising gate edge
  task automatic waitRise(output int n);
    logic prev;
    prev = swGate;
    for (n = 1; n < 300; n++) begin
      step(1);
      if (!prev && swGate === 1'b1) return;
      prev = swGate;
    end
  endtask : waitRise

  // on-time of the pulse just started
  task automatic highLen(output int h);
    h = 0;
    while (swGate === 1'b1 && h < 300) begin
      step(1);
      h++;
    end
  endtask : highLen

  // cycles until the target moves
  task automatic waitChange(output int g);
    logic [15:0] old;
    old = targetMv;
    for (g = 1; g < 100; g++) begin
      step(1);
      if (targetMv !== old) return;
    end
  endtask : waitChange

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_soft;
    int n, h, s;
    @(posedge clk);
    boostEn <= 1'b1;
    for (s = 0; s < 5 && softStart !== 1'b1; s++) step(1);
    `CHK("softStart", 1'b1, softStart)
    waitRise(n);
    highLen(h);
    `CHK("softOnCap", 1'b1, h <= 32)
    s = n + h;
    while (softStart === 1'b1 && s < 200) begin
      step(1);
      s++;
    end
    `CHK("softLen", 1'b1, s >= SS - 2 && s <= SS + 3)
    waitRise(n);
    highLen(h);
    `CHK("runOn", 1'b1, h > 32 && h <= 56)
    // early current trip: model delay, two sync flops, timer and output gate registers
    @(posedge clk);
    tripDelay <= 8'h05;
    waitRise(n);
    highLen(h);
    `CHK("tripOn", 9, h)
    @(posedge clk);
    tripDelay <= 8'hc8;
  endtask : t_soft

  task automatic t_freq;
    int sel[6] = '{0, 0, 0, 0, 1, 1};
    int code[6] = '{0, 1, 2, 3, 0, 2};
    int res[6] = '{3, 0, 0, 2, 2, 1};
    int pe[6] = '{64, 32, 16, 64, 16, 32};
    int n;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      resistorFreqSelect <= sel[i][0];
      switchFreqCode <= code[i][1:0];
      freqSetResistorCode <= res[i][1:0];
      waitRise(n);
      waitRise(n);
      waitRise(n);
      `CHK("period", pe[i], n)
    end
  endtask : t_freq

  task automatic t_spread;
    int n;
    logic varied;
    varied = 1'b0;
    @(posedge clk);
    resistorFreqSelect <= 1'b0;
    switchFreqCode <= 2'h2;
    spreadEnable <= 1'b1;
    waitRise(n);
    waitRise(n);
    for (int i = 0; i < 8; i++) begin
      waitRise(n);
      `CHK("spreadRange", 1'b1, n >= 16 && n <= 19)
      if (n != 16) varied = 1'b1;
    end
    `CHK("spreadVaries", 1'b1, varied)
    @(posedge clk);
    spreadEnable <= 1'b0;
  endtask : t_spread

  task automatic t_drv;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      secondDriverEnable <= i[0];
      thirdDriverEnable <= i[1];
      step(2);
      `CHK("drvEn", {i[1], i[0], 1'b1}, drvEn)
    end
  endtask : t_drv

  task automatic t_manual;
    int rg[5] = '{0, 0, 1, 0, 1};
    int sp[5] = '{0, 10, 5, 127, 20};
    int ce[5] = '{7, 7, 7, 5, 7};
    int ex[5] = '{7000, 11200, 18100, 25000, 24400};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      boostFloorRange <= rg[i][0];
      boostSetpoint <= sp[i][6:0];
      boostCeilingCode <= ce[i][2:0];
      step(3);
      `CHK("manualMv", ex[i], targetMv)
    end
    `CHK("thrOut", 3'h5, headroomThrOut)
    `CHK("hystOut", 2'h2, hysteresisOut)
  endtask : t_manual

  task automatic t_track;
    int g, v;
    @(posedge clk);
    boostFloorRange <= 1'b0;
    boostSetpoint <= 7'h0a;
    boostCeilingCode <= 3'h5;
    phaseShiftPattern <= 3'h0;
    openMask <= 6'h3e;
    marginMv <= 16'hea60;
    // setpoint settles one cycle before the loop loads it as start value
    @(posedge clk);
    trackEnable <= 1'b1;
    step(3 * UPD);
    `CHK("maskedHold", 11200, targetMv)
    `CHK("trackActive", 1'b1, trackActive)
    @(posedge clk);
    phaseShiftPattern <= 3'h5;
    for (int k = 0; k < 30 && targetMv !== 16'd25000; k++) begin
      v = (int'(targetMv) + 840 > 25000) ? 25000 : int'(targetMv) + 840;
      waitChange(g);
      `CHK("upStep", v, targetMv)
      if (k > 0) `CHK("upGap", 1'b1, g >= UPD - 1)
    end
    step(2 * UPD);
    `CHK("ceilHold", 25000, targetMv)
    `CHK("atCeiling", 1'b1, atCeiling)
    @(posedge clk);
    openMask <= 6'h00;
    marginMv <= 16'h0000;
    for (int k = 0; k < 20 && targetMv !== 16'd11200; k++) begin
      v = (int'(targetMv) - 1260 < 11200) ? 11200 : int'(targetMv) - 1260;
      waitChange(g);
      `CHK("dnStep", v, targetMv)
    end
    step(2 * UPD);
    `CHK("floorHold", 11200, targetMv)
    @(posedge clk);
    trackEnable <= 1'b0;
    step(3);
    `CHK("manualBack", 1'b0, trackActive)
  endtask : t_track

  // verdict
  task automatic report_and_stop;
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    step(3);
    `CHK("offDrv", 3'h0, drvEn)
    `CHK("offSoft", 1'b0, softStart)
    t_soft();
    t_freq();
    t_spread();
    t_drv();
    t_manual();
    t_track();
    report_and_stop();
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule : bvc_boost_ctrl_tb_top
